// >>> design/cdrs_top.sv
/*
 * Clock divider and reset sequencer of a small microcontroller.
 * Assumes core_clk is the oscillator, the reset pin and the oscillator-good
 * and delay-option straps are asynchronous, and the CPU and watchdog
 * signals come from logic on core_clk.
 */
// Summary of operation
// - Internal clock to Auto_reload_timer; /12 and /13
// - Instructions last two, four or five cycles
// - Select field divides by 1, 2, 4
// - Write-only control register at DCh
// - Bit three cleared by reset, set later
// - Pin, power-on or watchdog cause reset
// - Low pin holds reset in any mode
// - Short pin pulse still gets full delay
// - Reset in run halts, pulls up, restarts
// - Reset in stop starts oscillator, pulls up
// - Wait out delay after pin release
// - Power-up holds until oscillator runs, delays
// - Counter releases reset after 2048 cycles
// - Watchdog expiry resets, reinitialises watchdog
// - Watchdog reset gets full delay too
// - Reset clears stack, loads vector 0FFEh
// - Start in non-maskable interrupt context
// - Return serves pending interrupt first
// - Option selects 2048 or 32768 delay
`timescale 1ns/1ps
module cdrs_top #(
    parameter int unsigned DELAY_SHORT_CYC = cdrs_pkg::CDRS_DELAY_SHORT,
    parameter int unsigned DELAY_LONG_CYC = cdrs_pkg::CDRS_DELAY_LONG
) (
    // Clock and power-on reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Board pins and straps
    input wire logic reset_pin_n,
    input wire logic osc_running,
    input wire logic opt_long_delay,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Watchdog and CPU events
    input wire logic wdt_expire,
    input wire logic [1:0] instr_len,
    input wire logic return_from_interrupt,
    input wire logic irq_pending,
    // Clock ticks
    output logic auto_reload_timer_tick,
    output logic timer_adc_wdt_tick,
    output logic machine_cycle_tick,
    output logic instr_done,
    // Reset outputs
    output logic periph_reset,
    output logic io_pullup_input,
    output logic osc_restart,
    output logic low_power_en,
    // CPU start
    output logic pc_load,
    output logic [11:0] pc_value,
    output logic stack_clear,
    output logic nmi_context,
    output logic irq_service,
    output logic resume_next
);
    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Terminal count of the oscillator divider for a select code
    function automatic logic [1:0] div_last(input logic [1:0] sel);
        unique case (sel)
            cdrs_pkg::CDRS_SEL_DIV1: div_last = cdrs_pkg::CDRS_CNT_DIV1;
            cdrs_pkg::CDRS_SEL_DIV2: div_last = cdrs_pkg::CDRS_CNT_DIV2;
            default: div_last = cdrs_pkg::CDRS_CNT_DIV4;
        endcase
    endfunction

    // Machine cycles of one instruction; unused code taken as longest
    function automatic logic [2:0] mc_count(input logic [1:0] len);
        unique case (len)
            cdrs_pkg::CDRS_LEN_2: mc_count = cdrs_pkg::CDRS_MC_2;
            cdrs_pkg::CDRS_LEN_4: mc_count = cdrs_pkg::CDRS_MC_4;
            default: mc_count = cdrs_pkg::CDRS_MC_5;
        endcase
    endfunction

    localparam logic [15:0] DLY_SHORT_LAST = 16'(DELAY_SHORT_CYC - 1);
    localparam logic [15:0] DLY_LONG_LAST = 16'(DELAY_LONG_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic pin_meta_reg; // Synchroniser stage one, read only by stage two
    logic pin_ok_reg; // Pin released, synchronised
    logic osc_meta_reg;
    logic osc_ok_reg; // Oscillator running, synchronised
    logic opt_meta_reg;
    logic opt_sync_reg;
    logic pin_rst_n; // Either reset holds the bridge
    cdrs_pkg::cdrs_seq_e seq_reg; // Sequencer state
    logic long_reg; // Delay option caught while held
    logic wdt_cause_reg; // Last reset came from the watchdog
    logic [15:0] dly_cnt_reg; // Stabilisation counter
    logic [15:0] dly_last; // Terminal count for the chosen delay
    logic dly_done;
    logic [3:0] ctrl_reg; // Divider control, write only
    logic ctrl_wr;
    logic [1:0] div_cnt_reg; // Oscillator divider count
    logic int_tick_reg; // One internal clock cycle
    logic [2:0] mc_cnt_reg; // Machine cycles of current instruction
    logic [2:0] mc_len_reg; // Length caught at instruction start
    logic in_reset;

    assign pin_rst_n = arst_n & reset_pin_n;
    assign ctrl_wr = reg_wr && (reg_addr == cdrs_pkg::CDRS_ADDR_DIVCTL);
    assign in_reset = (seq_reg != cdrs_pkg::SEQ_RUN);
    assign dly_last = long_reg ? DLY_LONG_LAST : DLY_SHORT_LAST;
    assign dly_done = int_tick_reg && (dly_cnt_reg == dly_last);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    // Reset pin bridge: low takes effect at once, release after two edges
    always_ff @(posedge core_clk or negedge pin_rst_n) begin
        if (!pin_rst_n) begin
            pin_meta_reg <= 1'b0;
            pin_ok_reg <= 1'b0;
        end else begin
            pin_meta_reg <= 1'b1;
            pin_ok_reg <= pin_meta_reg;
        end
    end

    // Oscillator-good and delay option straps
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_meta_reg <= 1'b0;
            osc_ok_reg <= 1'b0;
            opt_meta_reg <= 1'b0;
            opt_sync_reg <= 1'b0;
        end else begin
            osc_meta_reg <= osc_running;
            osc_ok_reg <= osc_meta_reg;
            opt_meta_reg <= opt_long_delay;
            opt_sync_reg <= opt_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer

    // Any source forces hold; release only after the full delay
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_reg <= cdrs_pkg::SEQ_HOLD;
        end else if (!pin_ok_reg) begin
            seq_reg <= cdrs_pkg::SEQ_HOLD;
        end else begin
            unique case (seq_reg)
                cdrs_pkg::SEQ_HOLD: begin
                    // Count starts only once the oscillator is good
                    if (osc_ok_reg) begin
                        seq_reg <= cdrs_pkg::SEQ_DELAY;
                    end
                end
                cdrs_pkg::SEQ_DELAY: begin
                    if (dly_done) begin
                        seq_reg <= cdrs_pkg::SEQ_INIT;
                    end
                end
                cdrs_pkg::SEQ_INIT: begin
                    seq_reg <= cdrs_pkg::SEQ_RUN;
                end
                cdrs_pkg::SEQ_RUN: begin
                    // Watchdog goes back through the same hold and delay
                    if (wdt_expire) begin
                        seq_reg <= cdrs_pkg::SEQ_HOLD;
                    end
                end
            endcase
        end
    end

    // Option is caught while held, so it cannot move mid-count
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            long_reg <= 1'b0;
        end else if (seq_reg == cdrs_pkg::SEQ_HOLD) begin
            long_reg <= opt_sync_reg;
        end
    end

    // Remember what caused the last reset, for software
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wdt_cause_reg <= 1'b0;
        end else if (!pin_ok_reg) begin
            wdt_cause_reg <= 1'b0;
        end else if (seq_reg == cdrs_pkg::SEQ_RUN && wdt_expire) begin
            wdt_cause_reg <= 1'b1;
        end
    end

    // Stabilisation counter in internal clock cycles; the divider sits at
    // one during reset, so these are also oscillator cycles
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dly_cnt_reg <= '0;
        end else if (seq_reg != cdrs_pkg::SEQ_DELAY) begin
            dly_cnt_reg <= '0;
        end else if (int_tick_reg) begin
            dly_cnt_reg <= dly_cnt_reg + 16'h0001;
        end
    end

    // Reset outputs: I/O pulled up and peripherals, watchdog included, held
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_reset <= 1'b1;
            io_pullup_input <= 1'b1;
            osc_restart <= 1'b0;
        end else begin
            periph_reset <= in_reset;
            io_pullup_input <= in_reset;
            // Pulse when the pin or watchdog sends the sequencer back to hold restarts the oscillator; none at power-on
            osc_restart <= (seq_reg != cdrs_pkg::SEQ_HOLD) &&
                           (!pin_ok_reg || (seq_reg == cdrs_pkg::SEQ_RUN && wdt_expire));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divider control register

    // Write-only; upper nibble dropped; cleared by any reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= cdrs_pkg::CDRS_CTRL_RESET;
        end else if (in_reset) begin
            ctrl_reg <= cdrs_pkg::CDRS_CTRL_RESET;
        end else if (ctrl_wr) begin
            // Bit two is stored as written; software keeps it low
            ctrl_reg <= reg_wdata[cdrs_pkg::CDRS_CTRL_W-1:0];
        end
    end

    // Low power request follows bit three
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_power_en <= 1'b0;
        end else begin
            low_power_en <= ctrl_reg[cdrs_pkg::CDRS_BIT_LOWPWR];
        end
    end

    // Read port: the control register reads as zero since it has no
    // read path; software keeps a shadow copy instead
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == cdrs_pkg::CDRS_ADDR_STATUS) begin
            reg_rdata <= 8'h00;
            reg_rdata[cdrs_pkg::CDRS_ST_IN_RESET] <= in_reset;
            reg_rdata[cdrs_pkg::CDRS_ST_NMI] <= nmi_context;
            reg_rdata[cdrs_pkg::CDRS_ST_LONG] <= long_reg;
            reg_rdata[cdrs_pkg::CDRS_ST_WDT] <= wdt_cause_reg;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock dividers

    // Oscillator divider; a write restarts the count, a reset clear folds any high count back
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_reg <= 2'h0;
            int_tick_reg <= 1'b0;
        end else begin
            int_tick_reg <= (div_cnt_reg == div_last(ctrl_reg[1:0]));
            if (ctrl_wr || div_cnt_reg >= div_last(ctrl_reg[1:0])) begin
                div_cnt_reg <= 2'h0;
            end else begin
                div_cnt_reg <= div_cnt_reg + 2'h1;
            end
        end
    end

    // Internal clock goes straight to the auto-reload timer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            auto_reload_timer_tick <= 1'b0;
        end else begin
            auto_reload_timer_tick <= (div_cnt_reg == div_last(ctrl_reg[1:0]));
        end
    end

    // Timer, A/D and watchdog clock
    cdrs_divn #(.DIVISOR(cdrs_pkg::CDRS_TIMER_DIV)) u_div_timer (
        .clk(core_clk),
        .arst_n(arst_n),
        .clear(periph_reset),
        .tick_in(int_tick_reg),
        .tick_out(timer_adc_wdt_tick)
    );

    // CPU machine cycle
    cdrs_divn #(.DIVISOR(cdrs_pkg::CDRS_CPU_DIV)) u_div_cpu (
        .clk(core_clk),
        .arst_n(arst_n),
        .clear(periph_reset),
        .tick_in(int_tick_reg),
        .tick_out(machine_cycle_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Instruction timing

    // Length caught on the first machine cycle, done on the last
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mc_cnt_reg <= 3'h0;
            mc_len_reg <= cdrs_pkg::CDRS_MC_2;
            instr_done <= 1'b0;
        end else if (periph_reset) begin
            mc_cnt_reg <= 3'h0;
            instr_done <= 1'b0;
        end else begin
            instr_done <= 1'b0;
            if (machine_cycle_tick) begin
                if (mc_cnt_reg == 3'h0) begin
                    mc_len_reg <= mc_count(instr_len);
                end
                if (mc_cnt_reg != 3'h0 && mc_cnt_reg == mc_len_reg - 3'h1) begin
                    mc_cnt_reg <= 3'h0;
                    instr_done <= 1'b1;
                end else begin
                    mc_cnt_reg <= mc_cnt_reg + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU start and context

    // Vector load and stack clear for one cycle on leaving the delay
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_load <= 1'b0;
            stack_clear <= 1'b0;
            pc_value <= cdrs_pkg::CDRS_RESET_VECTOR;
        end else begin
            pc_load <= (seq_reg == cdrs_pkg::SEQ_INIT);
            stack_clear <= (seq_reg == cdrs_pkg::SEQ_INIT);
            pc_value <= cdrs_pkg::CDRS_RESET_VECTOR;
        end
    end

    // Non-maskable context from reset until the closing return
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            nmi_context <= 1'b1;
            irq_service <= 1'b0;
            resume_next <= 1'b0;
        end else if (in_reset) begin
            nmi_context <= 1'b1;
            irq_service <= 1'b0;
            resume_next <= 1'b0;
        end else begin
            irq_service <= return_from_interrupt && nmi_context && irq_pending;
            resume_next <= return_from_interrupt && nmi_context && !irq_pending;
            if (return_from_interrupt) begin
                nmi_context <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_leave_delay;
        seq_reg == cdrs_pkg::SEQ_DELAY ##1 seq_reg == cdrs_pkg::SEQ_INIT;
    endsequence

    sequence s_wdt_hit;
        seq_reg == cdrs_pkg::SEQ_RUN && wdt_expire && pin_ok_reg;
    endsequence

    a_div_one_rate: assert property (@(posedge core_clk) disable iff (!arst_n)
        ctrl_reg[1:0] == cdrs_pkg::CDRS_SEL_DIV1 ##1
        ctrl_reg[1:0] == cdrs_pkg::CDRS_SEL_DIV1 |=> int_tick_reg)
        else $error("divide by one missed a tick");

    a_div_slow_gap: assert property (@(posedge core_clk) disable iff (!arst_n)
        int_tick_reg && ctrl_reg[1:0] != cdrs_pkg::CDRS_SEL_DIV1 |=> !int_tick_reg)
        else $error("divided internal clock ticked too soon");

    a_pin_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
        !pin_ok_reg |=> seq_reg == cdrs_pkg::SEQ_HOLD ##1 periph_reset)
        else $error("reset pin low but sequencer not held");

    a_delay_count: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_leave_delay |-> $past(dly_cnt_reg) == dly_last && $past(int_tick_reg))
        else $error("reset released before full delay");

    a_init_vector: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_leave_delay |=> pc_load && stack_clear &&
        pc_value == cdrs_pkg::CDRS_RESET_VECTOR ##1 !pc_load)
        else $error("vector load missing after reset");

    a_nmi_start: assert property (@(posedge core_clk) disable iff (!arst_n)
        pc_load |-> nmi_context && io_pullup_input)
        else $error("CPU started outside non-maskable context");

    a_wdt_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_wdt_hit |=> seq_reg == cdrs_pkg::SEQ_HOLD && osc_restart ##1 periph_reset)
        else $error("watchdog did not restart the device");

    a_return_pending: assert property (@(posedge core_clk) disable iff (!arst_n)
        !in_reset && return_from_interrupt && nmi_context |=>
        irq_service == $past(irq_pending) && resume_next != irq_service && !nmi_context)
        else $error("return did not serve pending interrupt first");
endmodule // cdrs_top

// >>> design/cdrs_pkg.sv
/*
 * Constants shared by the clock divider and reset sequencer.
 * Assumes one oscillator clock drives the whole block.
 */
package cdrs_pkg;
    // Register map
    localparam logic [7:0] CDRS_ADDR_DIVCTL = 8'hdc;
    localparam logic [7:0] CDRS_ADDR_STATUS = 8'hdf;
    // Divider control fields
    localparam int CDRS_CTRL_W = 4;
    localparam int CDRS_SEL_LO = 0;
    localparam int CDRS_SEL_HI = 1;
    localparam int CDRS_BIT_KEEP_LOW = 2;
    localparam int CDRS_BIT_LOWPWR = 3;
    localparam logic [3:0] CDRS_CTRL_RESET = 4'h0;
    localparam logic [1:0] CDRS_SEL_DIV1 = 2'h0;
    localparam logic [1:0] CDRS_SEL_DIV2 = 2'h1;
    localparam logic [1:0] CDRS_CNT_DIV1 = 2'h0;
    localparam logic [1:0] CDRS_CNT_DIV2 = 2'h1;
    localparam logic [1:0] CDRS_CNT_DIV4 = 2'h3;
    // Status fields
    localparam int CDRS_ST_IN_RESET = 0;
    localparam int CDRS_ST_NMI = 1;
    localparam int CDRS_ST_LONG = 2;
    localparam int CDRS_ST_WDT = 3;
    // Fixed dividers of the internal clock
    localparam int CDRS_TIMER_DIV = 12;
    localparam int CDRS_CPU_DIV = 13;
    // Stabilisation delay, in internal clock cycles
    localparam int CDRS_DELAY_SHORT = 2048;
    localparam int CDRS_DELAY_LONG = 32768;
    localparam int CDRS_DLY_W = 16;
    // Start of program after reset
    localparam logic [11:0] CDRS_RESET_VECTOR = 12'hffe;
    // Instruction length codes and their machine cycle counts
    localparam logic [1:0] CDRS_LEN_2 = 2'h0;
    localparam logic [1:0] CDRS_LEN_4 = 2'h1;
    localparam logic [2:0] CDRS_MC_2 = 3'h2;
    localparam logic [2:0] CDRS_MC_4 = 3'h4;
    localparam logic [2:0] CDRS_MC_5 = 3'h5;
    // Reset sequencer states
    typedef enum logic [1:0] {SEQ_HOLD, SEQ_DELAY, SEQ_INIT, SEQ_RUN} cdrs_seq_e;
endpackage

// >>> design/cdrs_divn.sv
/*
 * Divide-by-N tick generator on a tick enable.
 * Assumes tick_in is a one-cycle pulse from the same clock.
 */
`timescale 1ns/1ps
module cdrs_divn #(
    parameter int unsigned DIVISOR = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic clear,
    input wire logic tick_in,
    // Divided tick
    output logic tick_out
);
    localparam int CW = $clog2(DIVISOR);
    localparam logic [CW-1:0] LAST = CW'(DIVISOR - 1);

    logic [CW-1:0] cnt_reg; // Input ticks seen in this period

    // Count input ticks; the wrap marks one output tick
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            tick_out <= 1'b0;
        end else if (clear) begin
            cnt_reg <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && (cnt_reg == LAST);
            if (tick_in) begin
                cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper: input ticks between two output ticks
    logic [CW:0] seen_reg;
    logic full_reg; // A whole period has been observed
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_reg <= '0;
            full_reg <= 1'b0;
        end else if (clear) begin
            seen_reg <= '0;
            full_reg <= 1'b0;
        end else if (tick_out) begin
            seen_reg <= {{CW{1'b0}}, tick_in};
            full_reg <= 1'b1;
        end else if (tick_in) begin
            seen_reg <= seen_reg + 1'b1;
        end
    end

    a_divn_ratio: assert property (@(posedge clk) disable iff (!arst_n)
        tick_out && full_reg && !$past(clear) |-> seen_reg == (CW+1)'(DIVISOR))
        else $error("divided tick period wrong");
endmodule // cdrs_divn

// >>> verif/cdrs_board_model.sv
/*
 * Board side: reset pin and oscillator-good line.
 * Assumes the bench raises pulse_req for one core_clk cycle.
 */
`timescale 1ns/1ps
module cdrs_board_model (
    // Clock and request
    input wire logic core_clk,
    input wire logic pulse_req,
    input wire logic [7:0] low_len,
    // Board pins
    output logic reset_pin_n,
    output logic osc_running
);
    // Cycles since power-up, low cycles left
    logic [7:0] up_cnt = 8'h00;
    logic [7:0] left = 8'h00;
    initial reset_pin_n = 1'b1;
    initial osc_running = 1'b0;
    // Oscillator comes up late so the hold before it is visible
    always @(posedge core_clk) begin
        if (up_cnt != 8'h14) up_cnt <= up_cnt + 8'h01;
        osc_running <= (up_cnt == 8'h14);
        if (pulse_req) left <= low_len;
        else if (left != 8'h00) left <= left - 8'h01;
        reset_pin_n <= !(pulse_req || left > 8'h01);
    end
endmodule // cdrs_board_model

// >>> verif/clock_divider_reset_sequencer_tb_top.sv
/*
 * Register-level bench of the clock divider and reset sequencer.
 * Assumes short delays of 16 and 64 cycles and a 125 MHz core_clk.
 */
`timescale 1ns/1ps
module clock_divider_reset_sequencer_tb_top;
    // Stimulus
    logic core_clk = 0, arst_n = 0, req = 0, opt = 0, wr = 0, rd = 0;
    logic wdt = 0, ret = 0, pend = 0;
    logic [7:0] low = 8'h01, addr = 8'h00, wd = 8'h00, got;
    logic [7:0] shadow = 8'h00; // Software image of the write-only control register
    logic [1:0] len = 2'h0;
    // Observed outputs
    logic pin_n, osc, art, tad, mct, idn, prst, pull, orst, lpw, pcl, stc, nmi, isv, rnx;
    logic [7:0] rdata;
    logic [11:0] pcv;
    logic [2:0] seen;
    int failures = 0, samples_checked = 0, n;
    int cnt[4];
    int mcs[4] = '{2, 4, 5, 5};
    always #4 core_clk = ~core_clk;
    cdrs_board_model board (.core_clk(core_clk), .pulse_req(req), .low_len(low),
        .reset_pin_n(pin_n), .osc_running(osc));
    cdrs_top #(.DELAY_SHORT_CYC(16), .DELAY_LONG_CYC(64)) dut (.core_clk(core_clk),
        .arst_n(arst_n), .reset_pin_n(pin_n), .osc_running(osc), .opt_long_delay(opt),
        .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .wdt_expire(wdt), .instr_len(len), .return_from_interrupt(ret), .irq_pending(pend),
        .auto_reload_timer_tick(art), .timer_adc_wdt_tick(tad), .machine_cycle_tick(mct),
        .instr_done(idn), .periph_reset(prst), .io_pullup_input(pull), .osc_restart(orst),
        .low_power_en(lpw), .pc_load(pcl), .pc_value(pcv), .stack_clear(stc),
        .nmi_context(nmi), .irq_service(isv), .resume_next(rnx));
    ////////////////////////////////////////////////////////////////////////////
    // Value compare
    task chk(input logic [11:0] g, input logic [11:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Cycle count compare; a window tolerates synchroniser latency
    task chk_rng(input int g, input int lo, input int hi);
        samples_checked++;
        if (g < lo || g > hi) begin
            failures++;
            $display("wrong value at %0t: %0d cycles", $time, g);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd_reg(input logic [7:0] a);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask
    // Wait for reset to be entered and left, noting the pulses seen
    task to_run();
        n = 0;
        seen = 3'h0;
        while (n < 300 && !(prst === 1'b0 && seen[2])) begin
            @(posedge core_clk);
            #1 n++;
            wdt <= 1'b0; // Watchdog request lasts one cycle
            if (prst === 1'b1 && pull === 1'b1) seen[2] = 1'b1;
            if (orst === 1'b1) seen[0] = 1'b1;
            if (pcl === 1'b1 && stc === 1'b1) seen[1] = 1'b1;
        end
    endtask
    task tally(input int w);
        cnt = '{default: 0};
        repeat (w) begin
            @(posedge core_clk);
            #1 cnt[0] += int'(art === 1'b1);
            cnt[1] += int'(tad === 1'b1);
            cnt[2] += int'(mct === 1'b1);
            cnt[3] += int'(idn === 1'b1);
        end
    endtask
    task print_verdict();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: whole run is under 7000 cycles
    initial begin
        #200000 failures++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        #1 chk({prst, pull, nmi}, 12'h007);
        to_run();
        chk(pcv, 12'hffe);
        chk({seen[1], nmi}, 12'h003);
        wr_reg(8'hdc, 8'hf8);
        wr_reg(8'h55, 8'h00);
        repeat (2) @(posedge core_clk);
        #1 chk(lpw, 1'b1);
        rd_reg(8'hdc);
        chk(got, 8'h00);
        rd_reg(8'h55);
        chk(got, 8'h00);
        // Every select code, ticks counted over a whole number of periods
        for (int s = 0; s < 4; s++) begin
            shadow = 8'h08 | s[7:0];
            wr_reg(8'hdc, shadow);
            repeat (200) @(posedge core_clk);
            tally(624);
            chk(12'(cnt[0]), 12'(624 / (s == 0 ? 1 : (s == 1 ? 2 : 4))));
            chk(12'(cnt[1] * 12), 12'(cnt[0]));
            chk(12'(cnt[2] * 13), 12'(cnt[0]));
        end
        shadow = 8'h08;
        wr_reg(8'hdc, shadow);
        for (int l = 0; l < 4; l++) begin
            len <= l[1:0];
            repeat (150) @(posedge core_clk);
            tally(260);
            chk(12'(cnt[3]), 12'(20 / mcs[l]));
        end
        @(posedge core_clk);
        ret <= 1'b1;
        @(posedge core_clk);
        ret <= 1'b0;
        #1 chk({nmi, isv, rnx}, 12'h001);
        req <= 1'b1;
        @(posedge core_clk);
        req <= 1'b0;
        to_run();
        chk_rng(n, 18, 32);
        chk({seen, lpw, nmi}, 12'h01d);
        pend <= 1'b1;
        ret <= 1'b1;
        @(posedge core_clk);
        ret <= 1'b0;
        #1 chk({nmi, isv, rnx}, 12'h002);
        wdt <= 1'b1;
        to_run();
        chk_rng(n, 18, 32);
        chk({seen, nmi}, 12'h00f);
        rd_reg(8'hdf);
        chk(got, 8'h0a);
        opt <= 1'b1;
        low <= 8'h05;
        @(posedge core_clk);
        req <= 1'b1;
        @(posedge core_clk);
        req <= 1'b0;
        to_run();
        chk_rng(n, 66, 84);
        rd_reg(8'hdf);
        chk(got, 8'h06);
        print_verdict();
    end
endmodule // clock_divider_reset_sequencer_tb_top
